// File: common/usb_ctl_pkg.sv
// Shared constants and types for the USB function control block.
// Assumes an APB register bus with 32-bit words, one register per word.
package usb_ctl_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_USB_CONTROL    = 10'h195;
    localparam logic [9:0] IDX_DEVICE_ADDRESS = 10'h196;
    localparam logic [9:0] IDX_FW_SCRATCH     = 10'h197;
    localparam logic [9:0] IDX_EP_CTL_BASE    = 10'h198;
    localparam logic [9:0] IDX_IRQ_STATUS     = 10'h1c0;
    localparam logic [9:0] IDX_IRQ_MASK       = 10'h1c1;
    localparam int         ADDR_LSB           = 2;

    localparam int NUM_ENDPOINTS = 3;
    localparam int EP_IDX_W      = 2;

    // Control register bit positions
    localparam int CTL_SE0_BIT      = 5;
    localparam int CTL_PACKET_DISABLE_BIT  = 4;
    localparam int CTL_CONFIG_BIT   = 3;
    localparam int CTL_RESUME_BIT   = 2;
    localparam int CTL_SUSPEND_BIT  = 1;

    // Endpoint control field positions
    localparam int EPC_CTL_DIS_BIT  = 3;
    localparam int EPC_OUT_EN_BIT   = 2;
    localparam int EPC_IN_EN_BIT    = 1;
    localparam int EPC_STALL_BIT    = 0;

    // Interrupt status bit positions
    localparam int IRQ_SETUP_BIT    = 0;
    localparam int IRQ_BUS_RST_BIT  = 1;
    localparam int IRQ_STALL_BIT    = 2;
    localparam int IRQ_REJECT_BIT   = 3;
    localparam int IRQ_W            = 4;

    // Reset values
    localparam logic [6:0]        RST_DEVICE_ADDRESS = 7'h00;
    localparam logic [7:0]        RST_FW_SCRATCH     = 8'h00;
    localparam logic [3:0]        RST_EP_CTL         = 4'h0;
    localparam logic [IRQ_W-1:0]  RST_IRQ_MASK       = 4'h0;

    typedef enum logic [1:0] {
        PID_OUT   = 2'h0,
        PID_IN    = 2'h1,
        PID_SETUP = 2'h2
    } token_pid_t;

    typedef enum logic [1:0] {
        VERDICT_IGNORE = 2'h0,
        VERDICT_ACCEPT = 2'h1,
        VERDICT_STALL  = 2'h2
    } verdict_t;

    typedef struct packed {
        logic       valid;
        token_pid_t pid;
        logic [6:0] addr;
        logic [3:0] ep;
    } token_t;

    typedef struct packed {
        logic accept;
        logic stall;
        logic ignore;
    } token_reply_t;

endpackage

// File: design/endpoint_decode.sv
// Decodes one endpoint control field against the token kind.
// Assumes the field is held in registers of the caller.
`timescale 1ns/10ps
module endpoint_decode (
    input  wire logic [3:0]                ctl,
    input  wire usb_ctl_pkg::token_pid_t   pid,
    output usb_ctl_pkg::verdict_t          verdict
);
    import usb_ctl_pkg::*;

    logic enabled;
    logic dir_ok;

    always_comb begin
        enabled = ctl[EPC_OUT_EN_BIT] | ctl[EPC_IN_EN_BIT];
        unique case (pid)
            PID_OUT:   dir_ok = ctl[EPC_OUT_EN_BIT];
            PID_IN:    dir_ok = ctl[EPC_IN_EN_BIT];
            PID_SETUP: dir_ok = ctl[EPC_OUT_EN_BIT] & ctl[EPC_IN_EN_BIT] & ~ctl[EPC_CTL_DIS_BIT];
            default:   dir_ok = 1'b0;
        endcase
        if (!enabled) begin
            verdict = VERDICT_IGNORE;
        end else if (ctl[EPC_STALL_BIT]) begin
            verdict = VERDICT_STALL;
        end else if (dir_ok) begin
            verdict = VERDICT_ACCEPT;
        end else begin
            verdict = VERDICT_IGNORE;
        end
    end

endmodule

// File: design/usb_function_control_regs.sv
// Control-side registers and token gating of a full-speed USB function.
// Assumes an APB master on pclk, a token decoder on pclk delivering one-cycle
// token strobes, a bus-reset pulse on pclk, and raw D+/D- pins from the pad.
//
// Behaviour
// - Live SE0 flag reads both lines low
// - SETUP token sets packet_disable
// - packet_disable holds off IN and OUT traffic
// - Resume bit drives resume signalling
// - Respond only to own device address
// - Address resets to 00h, both resets
// - Six endpoint directions, endpoints zero to two
// - Separate control register per endpoint
// - Four-bit control field per endpoint
// - Endpoint zero resets disabled; any endpoint can be a control pipe
`timescale 1ns/10ps
module usb_function_control_regs (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic                            pready,
    output logic [31:0]                     prdata,
    output logic                            pslverr,
    // USB line state and token decoder
    input  wire logic                       usb_dp,
    input  wire logic                       usb_dm,
    input  wire usb_ctl_pkg::token_t        token,
    input  wire logic                       bus_reset,
    output usb_ctl_pkg::token_reply_t       reply,
    // Link control
    output logic                            packet_disable,
    output logic                            resume_drive,
    output logic                            suspend_ctl,
    output logic                            usb_clk_en,
    output logic                            xcvr_enable,
    output logic                            irq
);
    import usb_ctl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Line state synchroniser

    logic [1:0] line_meta;
    logic [1:0] line_sync;
    logic       se0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_meta <= 2'h0;
            line_sync <= 2'h0;
        end else begin
            line_meta <= {usb_dp, usb_dm};
            line_sync <= line_meta;
        end
    end

    assign se0 = ~line_sync[1] & ~line_sync[0];

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    logic [9:0] reg_idx;
    logic       access;
    logic       wr_hit;
    logic       rd_hit;
    logic       idx_ctl;
    logic       idx_addr;
    logic       idx_scratch;
    logic       idx_status;
    logic       idx_mask;
    logic [NUM_ENDPOINTS-1:0] idx_ep;
    logic       mapped;

    assign reg_idx     = paddr[11:ADDR_LSB];
    assign access      = psel & penable & pready;
    assign wr_hit      = access & pwrite;
    assign rd_hit      = access & ~pwrite;
    assign idx_ctl     = (reg_idx == IDX_USB_CONTROL);
    assign idx_addr    = (reg_idx == IDX_DEVICE_ADDRESS);
    assign idx_scratch = (reg_idx == IDX_FW_SCRATCH);
    assign idx_status  = (reg_idx == IDX_IRQ_STATUS);
    assign idx_mask    = (reg_idx == IDX_IRQ_MASK);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_ENDPOINTS; gi++) begin : g_ep_idx
            assign idx_ep[gi] = (reg_idx == IDX_EP_CTL_BASE + 10'(gi));
        end
    endgenerate

    assign mapped = idx_ctl | idx_addr | idx_scratch | idx_status | idx_mask | (|idx_ep);

    ////////////////////////////////////////////////////////////////////////////
    // Register state

    logic       config_bit;
    logic       resume_bit;
    logic [6:0] device_address;
    logic [7:0] fw_scratch;
    logic [3:0] ep_ctl [NUM_ENDPOINTS];
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;

    logic       next_packet_disable;
    logic       next_config_bit;
    logic       next_resume_bit;
    logic       next_suspend_ctl;
    logic [6:0] next_device_address;
    logic [7:0] next_fw_scratch;
    logic [3:0] next_ep_ctl [NUM_ENDPOINTS];
    logic [IRQ_W-1:0] next_irq_status;
    logic [IRQ_W-1:0] next_irq_mask;
    logic [IRQ_W-1:0] irq_events;
    logic       setup_taken;

    always_comb begin
        next_packet_disable = packet_disable;
        next_config_bit     = config_bit;
        next_resume_bit     = resume_bit;
        next_suspend_ctl    = suspend_ctl;
        next_device_address = device_address;
        next_fw_scratch     = fw_scratch;
        next_irq_mask       = irq_mask;
        for (int i = 0; i < NUM_ENDPOINTS; i++) begin
            next_ep_ctl[i] = ep_ctl[i];
        end
        if (wr_hit && idx_ctl) begin
            next_config_bit  = pwdata[CTL_CONFIG_BIT];
            next_suspend_ctl = pwdata[CTL_SUSPEND_BIT];
            // Frozen while suspended: clocks to the engine are stopped
            if (!suspend_ctl) begin
                next_resume_bit = pwdata[CTL_RESUME_BIT];
                if (!pwdata[CTL_PACKET_DISABLE_BIT]) begin
                    next_packet_disable = 1'b0;
                end
            end
        end
        if (wr_hit && idx_addr) begin
            next_device_address = pwdata[6:0];
        end
        if (wr_hit && idx_scratch) begin
            next_fw_scratch = pwdata[7:0];
        end
        if (wr_hit && idx_mask) begin
            next_irq_mask = pwdata[IRQ_W-1:0];
        end
        for (int i = 0; i < NUM_ENDPOINTS; i++) begin
            if (wr_hit && idx_ep[i]) begin
                next_ep_ctl[i] = pwdata[3:0];
            end
        end
        // Set wins over the firmware clear in the same cycle
        if (setup_taken) begin
            next_packet_disable = 1'b1;
        end
        // Bus reset wins over a concurrent address write
        if (bus_reset) begin
            next_device_address = RST_DEVICE_ADDRESS;
        end
        next_irq_status = irq_status;
        if (rd_hit && idx_status) begin
            next_irq_status = '0;
        end
        next_irq_status = next_irq_status | irq_events;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            packet_disable <= 1'b0;
            config_bit     <= 1'b0;
            resume_bit     <= 1'b0;
            suspend_ctl    <= 1'b0;
            device_address <= RST_DEVICE_ADDRESS;
            fw_scratch     <= RST_FW_SCRATCH;
            irq_status     <= '0;
            irq_mask       <= RST_IRQ_MASK;
            for (int i = 0; i < NUM_ENDPOINTS; i++) begin
                ep_ctl[i] <= RST_EP_CTL;
            end
        end else begin
            packet_disable <= next_packet_disable;
            config_bit     <= next_config_bit;
            resume_bit     <= next_resume_bit;
            suspend_ctl    <= next_suspend_ctl;
            device_address <= next_device_address;
            fw_scratch     <= next_fw_scratch;
            irq_status     <= next_irq_status;
            irq_mask       <= next_irq_mask;
            for (int i = 0; i < NUM_ENDPOINTS; i++) begin
                ep_ctl[i] <= next_ep_ctl[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Token gating

    verdict_t    ep_verdict [NUM_ENDPOINTS];
    verdict_t    verdict;
    logic        addr_match;
    logic        ep_in_range;
    token_reply_t next_reply;

    generate
        for (gi = 0; gi < NUM_ENDPOINTS; gi++) begin : g_ep_dec
            // One field serves both directions of its endpoint
            endpoint_decode u_dec (
                .ctl     (ep_ctl[gi]),
                .pid     (token.pid),
                .verdict (ep_verdict[gi])
            );
        end
    endgenerate

    always_comb begin
        addr_match  = (token.addr == device_address);
        ep_in_range = (token.ep < 4'(NUM_ENDPOINTS));
        verdict     = VERDICT_IGNORE;
        if (ep_in_range) begin
            verdict = ep_verdict[token.ep[EP_IDX_W-1:0]];
        end
        // SETUP still gets through so back-to-back SETUPs are seen
        if (packet_disable && token.pid != PID_SETUP) begin
            verdict = VERDICT_IGNORE;
        end
        if (!addr_match || suspend_ctl || bus_reset) begin
            verdict = VERDICT_IGNORE;
        end
        next_reply.accept = token.valid & (verdict == VERDICT_ACCEPT);
        next_reply.stall  = token.valid & (verdict == VERDICT_STALL);
        next_reply.ignore = token.valid & (verdict == VERDICT_IGNORE);
        setup_taken       = next_reply.accept & (token.pid == PID_SETUP);
        irq_events                   = '0;
        irq_events[IRQ_SETUP_BIT]    = setup_taken;
        irq_events[IRQ_BUS_RST_BIT]  = bus_reset;
        irq_events[IRQ_STALL_BIT]    = next_reply.stall;
        irq_events[IRQ_REJECT_BIT]   = token.valid & addr_match & (verdict == VERDICT_IGNORE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reply <= '0;
        end else begin
            reply <= next_reply;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link control outputs

    logic next_resume_drive;
    logic next_usb_clk_en;
    logic next_xcvr_enable;
    logic next_irq;

    always_comb begin
        next_resume_drive = next_resume_bit;
        next_usb_clk_en   = ~next_suspend_ctl;
        next_xcvr_enable  = ~next_suspend_ctl;
        next_irq          = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resume_drive <= 1'b0;
            usb_clk_en   <= 1'b1;
            xcvr_enable  <= 1'b1;
            irq          <= 1'b0;
        end else begin
            resume_drive <= next_resume_drive;
            usb_clk_en   <= next_usb_clk_en;
            xcvr_enable  <= next_xcvr_enable;
            irq          <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB answer: one wait state so read data comes from a flop

    logic [31:0] rd_value;
    logic        next_pready;
    logic [31:0] next_prdata;
    logic        next_pslverr;

    always_comb begin
        rd_value = '0;
        if (idx_ctl) begin
            rd_value[CTL_SE0_BIT]     = se0;
            rd_value[CTL_PACKET_DISABLE_BIT] = packet_disable;
            rd_value[CTL_CONFIG_BIT]  = config_bit;
            rd_value[CTL_RESUME_BIT]  = resume_bit;
            rd_value[CTL_SUSPEND_BIT] = suspend_ctl;
        end
        if (idx_addr) begin
            rd_value[6:0] = device_address;
        end
        if (idx_scratch) begin
            rd_value[7:0] = fw_scratch;
        end
        if (idx_status) begin
            rd_value[IRQ_W-1:0] = irq_status;
        end
        if (idx_mask) begin
            rd_value[IRQ_W-1:0] = irq_mask;
        end
        for (int i = 0; i < NUM_ENDPOINTS; i++) begin
            if (idx_ep[i]) begin
                rd_value[3:0] = ep_ctl[i];
            end
        end
        next_pready  = psel & penable & ~pready;
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        if (next_pready) begin
            next_prdata  = pwrite ? 32'h0000_0000 : rd_value;
            next_pslverr = ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= next_pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

endmodule

// File: sim/usb_ctl_monitor.sv
// Concurrent checks on the ports of the USB function control block.
// Assumes one pclk domain; bound onto the design from tb_top.
`timescale 1ns/10ps
module usb_ctl_monitor (
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic                      pready,
    input wire logic [31:0]               prdata,
    input wire logic                      pslverr,
    input wire usb_ctl_pkg::token_t       token,
    input wire logic                      bus_reset,
    input wire usb_ctl_pkg::token_reply_t reply,
    input wire logic                      packet_disable,
    input wire logic                      resume_drive,
    input wire logic                      suspend_ctl,
    input wire logic                      usb_clk_en,
    input wire logic                      xcvr_enable,
    input wire logic                      irq
);
    import usb_ctl_pkg::*;
    logic apb_wr;
    assign apb_wr = psel && penable && pready && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    property p_pready_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
    property p_err_data; pready && pslverr |-> prdata == 32'h0; endproperty
    property p_reply_one; token.valid |=> $onehot({reply.accept, reply.stall, reply.ignore}); endproperty
    property p_reply_idle; !token.valid |=> {reply.accept, reply.stall, reply.ignore} == 3'h0; endproperty
    property p_setup_sets; token.valid && token.pid == PID_SETUP ##1 reply.accept |-> packet_disable; endproperty
    property p_pd_blocks; token.valid && packet_disable && token.pid != PID_SETUP |=> !reply.accept; endproperty
    property p_susp_ignore; token.valid && suspend_ctl |=> reply.ignore; endproperty
    property p_susp_off; suspend_ctl [*2] |-> !usb_clk_en && !xcvr_enable; endproperty
    property p_susp_on; !suspend_ctl [*2] |-> usb_clk_en && xcvr_enable; endproperty
    property p_pd_hold; suspend_ctl && packet_disable |=> packet_disable; endproperty
    property p_bus_reset; bus_reset && token.valid |=> reply.ignore; endproperty
    // Resume output may only move as a result of a register write
    property p_resume_src; $changed(resume_drive) |-> $past(apb_wr) || $past(apb_wr, 2); endproperty
    ////////////////////////////////////////
    a_pready_wait: assert property (p_pready_wait) else $error("pready not on second access cycle");
    a_err_data: assert property (p_err_data) else $error("read data not zero on slave error");
    a_reply_one: assert property (p_reply_one) else $error("token reply not exactly one flag");
    a_reply_idle: assert property (p_reply_idle) else $error("reply without token");
    a_setup_sets: assert property (p_setup_sets) else $error("accepted setup left gate open");
    a_pd_blocks: assert property (p_pd_blocks) else $error("traffic accepted while gated");
    a_susp_ignore: assert property (p_susp_ignore) else $error("token answered in suspend");
    a_susp_off: assert property (p_susp_off) else $error("clocks running in suspend");
    a_susp_on: assert property (p_susp_on) else $error("clocks stopped out of suspend");
    a_pd_hold: assert property (p_pd_hold) else $error("gate cleared during suspend");
    a_bus_reset: assert property (p_bus_reset) else $error("token answered during bus reset");
    a_resume_src: assert property (p_resume_src) else $error("resume moved without write");
    c_setup: cover property (token.valid && token.pid == PID_SETUP ##1 reply.accept);
    c_stall: cover property (reply.stall);
    c_err: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
endmodule

// File: sim/usb_host_model.sv
// Host side of the cable: line state, token strobes and bus reset.
// Assumes its tasks are entered just after a rising pclk edge.
`timescale 1ns/10ps
module usb_host_model (
    input wire logic                      pclk,
    input wire usb_ctl_pkg::token_reply_t reply,
    output logic                          usb_dp,
    output logic                          usb_dm,
    output usb_ctl_pkg::token_t           token,
    output logic                          bus_reset
);
    import usb_ctl_pkg::*;
    // Idle J state: pull-up on D+
    initial begin
        usb_dp = 1'b1;
        usb_dm = 1'b0;
        token = '0;
        bus_reset = 1'b0;
    end
    task automatic send(input token_pid_t pid, input logic [6:0] addr, input logic [3:0] ep,
                        output token_reply_t r);
        token <= '{valid: 1'b1, pid: pid, addr: addr, ep: ep};
        @(posedge pclk);
        // Idle fields toggle so stale values never look valid
        token <= '{valid: 1'b0, pid: token_pid_t'(~token.pid), addr: ~token.addr, ep: ~token.ep};
        @(posedge pclk);
        r = reply;
    endtask
    task automatic line_state(input logic dp, input logic dm);
        usb_dp <= dp;
        usb_dm <= dm;
    endtask
    task automatic reset_bus;
        bus_reset <= 1'b1;
        @(posedge pclk);
        bus_reset <= 1'b0;
        @(posedge pclk);
    endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the USB function control block.
// Assumes APB master here and the host model on the USB side.
`timescale 1ns/10ps
`define CHECK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
    import usb_ctl_pkg::*;
    localparam token_reply_t ACC = 3'h4;
    localparam token_reply_t STL = 3'h2;
    localparam token_reply_t IGN = 3'h1;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, rd, v;
    logic pready, pslverr, usb_dp, usb_dm, bus_reset, packet_disable, resume_drive;
    logic suspend_ctl, usb_clk_en, xcvr_enable, irq, err;
    logic [31:0] prdata;
    logic [6:0] dev;
    token_t token;
    token_reply_t reply, r;
    int fails = 0, n_tests = 0, cycles = 0;
    always #4 pclk = ~pclk;
    usb_function_control_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .usb_dp(usb_dp), .usb_dm(usb_dm), .token(token), .bus_reset(bus_reset),
        .reply(reply), .packet_disable(packet_disable), .resume_drive(resume_drive),
        .suspend_ctl(suspend_ctl), .usb_clk_en(usb_clk_en), .xcvr_enable(xcvr_enable), .irq(irq));
    usb_host_model host (.pclk(pclk), .reply(reply), .usb_dp(usb_dp), .usb_dm(usb_dm), .token(token),
        .bus_reset(bus_reset));
    ////////////////////////////////////////
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait-state count assumed; only the bench timeout ends a hang
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] d); apb(1'b1, idx, d); endtask
    task automatic rdchk(input logic [9:0] idx, input logic [31:0] e); apb(1'b0, idx, 32'h0); `CHECK(rd, e) endtask
    task automatic tok(input token_pid_t p, input logic [6:0] a, input logic [3:0] ep, input token_reply_t e);
        host.send(p, a, ep, r);
        `CHECK(r, e)
    endtask
    function automatic token_reply_t expect_v(input logic [3:0] c, input token_pid_t p);
        if (!c[EPC_OUT_EN_BIT] && !c[EPC_IN_EN_BIT]) return IGN;
        if (c[EPC_STALL_BIT]) return STL;
        if (p == PID_SETUP) return (c[3:1] == 3'b011) ? ACC : IGN;
        if (p == PID_OUT) return c[EPC_OUT_EN_BIT] ? ACC : IGN;
        return c[EPC_IN_EN_BIT] ? ACC : IGN;
    endfunction
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'hb02c2ca4));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(IDX_DEVICE_ADDRESS, 32'h0);
        rdchk(IDX_USB_CONTROL, 32'h0);
        for (int i = 0; i < 3; i++) rdchk(IDX_EP_CTL_BASE + 10'(i), 32'h0);
        apb(1'b0, 10'h3ff, 32'h0);
        `CHECK({err, rd}, 33'h1_0000_0000)
        $display("test reset and map done");
        host.line_state(1'b0, 1'b0);
        repeat (4) @(posedge pclk);
        rdchk(IDX_USB_CONTROL, 32'h20);
        host.line_state(1'b1, 1'b0);
        repeat (4) @(posedge pclk);
        rdchk(IDX_USB_CONTROL, 32'h0);
        $display("test line state done");
        for (int i = 0; i < 6; i++) begin
            v = $urandom;
            wr(IDX_DEVICE_ADDRESS, v);
            rdchk(IDX_DEVICE_ADDRESS, v & 32'h7f);
            wr(IDX_FW_SCRATCH, v);
            rdchk(IDX_FW_SCRATCH, v & 32'hff);
            wr(IDX_EP_CTL_BASE + 10'(i % 3), v);
            rdchk(IDX_EP_CTL_BASE + 10'(i % 3), v & 32'hf);
        end
        $display("test registers done");
        dev = 7'($urandom);
        wr(IDX_DEVICE_ADDRESS, {25'h0, dev});
        for (int c = 0; c < 16; c++) begin
            for (int p = 0; p < 3; p++) begin
                wr(IDX_EP_CTL_BASE + 10'h1, c);
                wr(IDX_USB_CONTROL, 32'h0);
                tok(token_pid_t'(p), dev ^ 7'h1, 4'h1, IGN);
                tok(token_pid_t'(p), dev, 4'h3, IGN);
                tok(token_pid_t'(p), dev, 4'h1, expect_v(4'(c), token_pid_t'(p)));
            end
        end
        $display("test endpoint decode done");
        wr(IDX_EP_CTL_BASE, 32'h6);
        wr(IDX_EP_CTL_BASE + 10'h1, 32'h0);
        wr(IDX_EP_CTL_BASE + 10'h2, 32'h0);
        wr(IDX_USB_CONTROL, 32'h0);
        tok(PID_SETUP, dev, 4'h0, ACC);
        rdchk(IDX_USB_CONTROL, 32'h10);
        tok(PID_OUT, dev, 4'h0, IGN);
        tok(PID_SETUP, dev, 4'h0, ACC);
        wr(IDX_USB_CONTROL, 32'h10);
        rdchk(IDX_USB_CONTROL, 32'h10);
        wr(IDX_USB_CONTROL, 32'h0);
        tok(PID_IN, dev, 4'h0, ACC);
        $display("test packet gate done");
        apb(1'b0, IDX_IRQ_STATUS, 32'h0);
        wr(IDX_IRQ_MASK, 32'h1);
        rdchk(IDX_IRQ_MASK, 32'h1);
        tok(PID_SETUP, dev, 4'h0, ACC);
        repeat (2) @(posedge pclk);
        `CHECK(irq, 1'b1)
        rdchk(IDX_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge pclk);
        `CHECK(irq, 1'b0)
        wr(IDX_IRQ_MASK, 32'h0);
        tok(PID_SETUP, dev, 4'h0, ACC);
        repeat (2) @(posedge pclk);
        `CHECK(irq, 1'b0)
        wr(IDX_IRQ_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        `CHECK(irq, 1'b1)
        apb(1'b0, IDX_IRQ_STATUS, 32'h0);
        $display("test interrupt done");
        wr(IDX_DEVICE_ADDRESS, 32'h2a);
        host.reset_bus();
        rdchk(IDX_DEVICE_ADDRESS, 32'h0);
        rdchk(IDX_IRQ_STATUS, 32'h2);
        rdchk(IDX_EP_CTL_BASE, 32'h6);
        wr(IDX_USB_CONTROL, 32'h0);
        tok(PID_OUT, 7'h2a, 4'h0, IGN);
        tok(PID_OUT, 7'h0, 4'h0, ACC);
        wr(IDX_DEVICE_ADDRESS, 32'h55);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(IDX_DEVICE_ADDRESS, 32'h0);
        $display("test address reset done");
        wr(IDX_USB_CONTROL, 32'h4);
        repeat (2) @(posedge pclk);
        `CHECK(resume_drive, 1'b1)
        wr(IDX_USB_CONTROL, 32'h0);
        repeat (2) @(posedge pclk);
        `CHECK(resume_drive, 1'b0)
        wr(IDX_EP_CTL_BASE, 32'h6);
        tok(PID_SETUP, 7'h0, 4'h0, ACC);
        wr(IDX_USB_CONTROL, 32'h1a);
        repeat (2) @(posedge pclk);
        `CHECK({usb_clk_en, xcvr_enable, suspend_ctl}, 3'b001)
        tok(PID_SETUP, 7'h0, 4'h0, IGN);
        rdchk(IDX_USB_CONTROL, 32'h1a);
        wr(IDX_USB_CONTROL, 32'h0);
        rdchk(IDX_USB_CONTROL, 32'h10);
        `CHECK({usb_clk_en, xcvr_enable, suspend_ctl}, 3'b110)
        wr(IDX_USB_CONTROL, 32'h0);
        rdchk(IDX_USB_CONTROL, 32'h0);
        $display("test resume and suspend done");
        conclude();
    end
endmodule
bind usb_function_control_regs usb_ctl_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .token(token), .bus_reset(bus_reset), .reply(reply), .packet_disable(packet_disable),
    .resume_drive(resume_drive), .suspend_ctl(suspend_ctl), .usb_clk_en(usb_clk_en),
    .xcvr_enable(xcvr_enable), .irq(irq));
